// ### design/link_tpg_defines.svh
// Purpose: Offsets, field positions, codes and seeds of the link test pattern block
// Assumes: Registers addressed with 15-bit serial port addresses
// Notes: Definitions only
`ifndef LINK_TPG_DEFINES_SVH
`define LINK_TPG_DEFINES_SVH
// Register offsets
`define ADDR_IFCFG      15'h0000
`define ADDR_UPAT_FIRST 15'h0551
`define ADDR_UPAT_LAST  15'h0558
`define ADDR_LTCTRL     15'h0573
`define ADDR_LLTCTRL    15'h0574
// Field positions and reset values
`define MODE_MSB        3
`define MODE_LSB        0
`define POINT_MSB       5
`define POINT_LSB       4
`define LTCTRL_RESET    6'h00
`define IFCFG_SRST_MASK 8'h81
`define IFCFG_KEEP_MASK 8'h7E
// Pattern modes
`define MODE_OFF        4'h0
`define MODE_ALT        4'h1
`define MODE_TOGGLE     4'h2
`define MODE_PN31       4'h3
`define MODE_PRBS_TWENTYTHREE_STAGE       4'h4
`define MODE_PN15       4'h5
`define MODE_PN9        4'h6
`define MODE_PN7        4'h7
`define MODE_RAMP       4'h8
`define MODE_UREP       4'hE
`define MODE_USGL       4'hF
// Injection points
`define PT_SAMPLE       2'h0
`define PT_SYMBOL       2'h1
`define PT_OCTET        2'h2
// Seeds and constant words
`define SEED_PN31       31'h0003AFFF
`define SEED_PRBS_TWENTYTHREE_STAGE       31'h00003AFF
`define SEED_PN15       31'h000003AF
`define SEED_PN9        31'h00000092
`define SEED_PN7        31'h00000007
`define ALT_WORD        16'h5555
`define FRAME_SLOT_LAST 2'h3
`define USER_IDX_LAST   2'h3
`define FIFO_DEPTH      8
`endif

// ### design/link_tpg_pkg.sv
// Purpose: Types shared by the link test pattern block
// Assumes: Constants live in link_tpg_defines.svh
// Notes: Types only
package link_tpg_pkg;
   typedef struct packed
   {
      logic [1:0] point;
      logic [3:0] mode;
   } test_ctrl_s;
   typedef struct packed
   {
      logic [30:0] state;
      logic [15:0] word;
   } prbs_s;
   typedef struct packed
   {
      logic [1:0]  point;
      logic [15:0] data;
   } link_word_s;
   typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA} spi_state_e;
endpackage : link_tpg_pkg

// ### design/link_tpg.sv
// Purpose: Link test pattern generator with serial register port and output FIFO
// Assumes: Serial port clock well below clk/8; MSB-first transfers only
// Notes: Pattern words are tagged with the injection point they belong to
`timescale 1ns/100ps
`include "link_tpg_defines.svh"

// Output FIFO with registered head word
module link_word_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Fill side
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   // Drain side
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   logic [AW:0]      countNext;

   // Head register reloads whenever it is free or being taken
   assign push      = inValid && inReady;
   assign pop       = (count != '0) && (!outValid || outReady);
   assign countNext = count + (AW+1)'(push) - (AW+1)'(pop);

   // Storage and pointers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            mem[wrPtr] <= inData;
            wrPtr      <= AW'(wrPtr + 1'b1);
         end
         if (pop)
            rdPtr <= AW'(rdPtr + 1'b1);
         count <= countNext;
      end
   end

   // Ready is registered from the next count, so it drops on the same edge that fills the FIFO
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         inReady <= 1'b0;
      else
         inReady <= (countNext != (AW+1)'(DEPTH));
   end

   // Head word
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         outValid <= 1'b0;
         outData  <= '0;
      end
      else if (pop)
      begin
         outValid <= 1'b1;
         outData  <= mem[rdPtr];
      end
      else if (outReady)
         outValid <= 1'b0;
   end
endmodule : link_word_fifo

// What this block does
// - Low nibble of control picks pattern
// - Bits five to four pick injection point
// - Active pattern replaces normal datapath words
// - Soft reset request bits clear themselves
// - Checkerboard and word toggle patterns
// - Long pseudorandom sequences with given seeds
// - Short pseudorandom sequences with given seeds
// - Ramp wraps at injection word width
// - Four user words repeat continuously
// - Four user words once, then zeros
// - Sample point: one word per frame
// - Symbol point: per symbol, top ten bits
// - Octet point: per octet, stream split
// - Sample patterns match standard receiver checker
// - User words come from pattern registers
module link_tpg
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // Serial register port
   input  wire logic                     spiClk,
   input  wire logic                     spiCs_b,
   input  wire logic                     sdioIn,
   output logic                          sdioOut,
   output logic                          sdioOe,
   // Normal datapath words
   input  wire logic                     srcValid,
   input  wire logic [15:0]              srcWord,
   output logic                          srcReady,
   // Words toward the link
   output logic                          linkValid,
   output link_tpg_pkg::link_word_s      linkWord,
   input  wire logic                     linkReady
);
   import link_tpg_pkg::*;

   // Word width at each injection point
   function automatic logic [4:0] widthOf(input logic [1:0] pt);
      case (pt)
         `PT_SYMBOL: widthOf = 5'd10;
         `PT_OCTET:  widthOf = 5'd8;
         default:    widthOf = 5'd16;
      endcase
   endfunction : widthOf

   function automatic logic [30:0] seedFor(input logic [3:0] m);
      case (m)
         `MODE_PN31: seedFor = `SEED_PN31;
         `MODE_PRBS_TWENTYTHREE_STAGE: seedFor = `SEED_PRBS_TWENTYTHREE_STAGE;
         `MODE_PN15: seedFor = `SEED_PN15;
         `MODE_PN9:  seedFor = `SEED_PN9;
         default:    seedFor = `SEED_PN7;
      endcase
   endfunction : seedFor

   // Next nBits of the stream, first bit at the word's top
   function automatic prbs_s prbsNext(input logic [30:0] st, input logic [3:0] m,
                                      input logic [4:0] nBits);
      logic [30:0] s;
      logic [15:0] w;
      logic        fb;
      int          top;
      s   = st;
      w   = '0;
      fb  = 1'b0;
      top = 6;
      // Top stage of the register for each sequence length
      case (m)
         `MODE_PN31: top = 30;
         `MODE_PRBS_TWENTYTHREE_STAGE: top = 22;
         `MODE_PN15: top = 14;
         `MODE_PN9:  top = 8;
         default:    top = 6;
      endcase
      for (int i = 0; i < 16; i++)
      begin
         if (i < int'(nBits))
         begin
            case (m)
               `MODE_PN31: fb = s[0] ^ s[3];
               `MODE_PRBS_TWENTYTHREE_STAGE: fb = s[0] ^ s[5];
               `MODE_PN15: fb = s[0] ^ s[1];
               `MODE_PN9:  fb = s[0] ^ s[4];
               default:    fb = s[0] ^ s[1];
            endcase
            // Oldest bit leaves first, so the seed opens the stream
            w      = {w[14:0], s[0]};
            s      = s >> 1;
            s[top] = fb;
         end
      end
      prbsNext = '{state: s, word: w};
   endfunction : prbsNext

   // Register read mux, used for first and streamed bytes
   logic [7:0] ifCfgReg;
   logic [7:0] userPat [8];
   test_ctrl_s ctrlReg;
   logic [7:0] lltReg;
   function automatic logic [7:0] regRead(input logic [14:0] a);
      regRead = 8'h00;
      if (a == `ADDR_IFCFG)
         regRead = ifCfgReg;
      else if (a >= `ADDR_UPAT_FIRST && a <= `ADDR_UPAT_LAST)
         regRead = userPat[3'(a - `ADDR_UPAT_FIRST)];
      else if (a == `ADDR_LTCTRL)
         regRead = {2'b00, ctrlReg};
      else if (a == `ADDR_LLTCTRL)
         regRead = lltReg;
   endfunction : regRead

   // Pins cross into clk through two flops each
   logic [2:0] pinRaw;
   logic [2:0] pinMeta;
   logic [2:0] pinSync;
   logic [2:0] pinDly;
   assign pinRaw = {spiClk, spiCs_b, sdioIn};
   generate
      for (genvar g = 0; g < 3; g++)
      begin : gSync
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               // Select resets to its idle high level so no frame starts
               pinMeta[g] <= 1'(g == 1);
               pinSync[g] <= 1'(g == 1);
               pinDly[g]  <= 1'(g == 1);
            end
            else
            begin
               pinMeta[g] <= pinRaw[g];
               pinSync[g] <= pinMeta[g];
               pinDly[g]  <= pinSync[g];
            end
         end
      end
   endgenerate

   logic sclkRise;
   logic sclkFall;
   logic csIdle;
   assign sclkRise = pinSync[2] && !pinDly[2];
   assign sclkFall = !pinSync[2] && pinDly[2];
   assign csIdle   = pinSync[1];

   // Serial port frame: 16-bit instruction, then streamed bytes
   spi_state_e  spiState;
   logic [15:0] shiftIn;
   logic [3:0]  bitCnt;
   logic        isRead;
   logic [14:0] addrReg;
   logic [7:0]  rdShift;
   logic        wrEnReg;
   logic [14:0] wrAddrReg;
   logic [7:0]  wrDataReg;
   logic [15:0] shiftNext;
   assign shiftNext = {shiftIn[14:0], pinSync[0]};

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         spiState  <= SPI_IDLE;
         shiftIn   <= '0;
         bitCnt    <= '0;
         isRead    <= 1'b0;
         addrReg   <= '0;
         rdShift   <= '0;
         wrEnReg   <= 1'b0;
         wrAddrReg <= '0;
         wrDataReg <= '0;
         sdioOut   <= 1'b0;
         sdioOe    <= 1'b0;
      end
      else
      begin
         wrEnReg <= 1'b0;
         if (csIdle)
         begin
            spiState <= SPI_IDLE;
            sdioOe   <= 1'b0;
         end
         else
         begin
            case (spiState)
               SPI_IDLE:
               begin
                  bitCnt   <= '0;
                  spiState <= SPI_INSTR;
               end
               SPI_INSTR:
               begin
                  if (sclkRise)
                  begin
                     shiftIn <= shiftNext;
                     bitCnt  <= 4'(bitCnt + 1'b1);
                     if (bitCnt == 4'hF)
                     begin
                        isRead   <= shiftNext[15];
                        addrReg  <= shiftNext[14:0];
                        rdShift  <= regRead(shiftNext[14:0]);
                        spiState <= SPI_DATA;
                     end
                  end
               end
               SPI_DATA:
               begin
                  if (sclkRise)
                  begin
                     shiftIn <= shiftNext;
                     bitCnt  <= {1'b0, 3'(bitCnt[2:0] + 1'b1)};
                     if (bitCnt[2:0] == 3'h7)
                     begin
                        // Streaming moves to the next address each byte
                        addrReg <= 15'(addrReg + 1'b1);
                        rdShift <= regRead(15'(addrReg + 1'b1));
                        if (!isRead)
                        begin
                           wrEnReg   <= 1'b1;
                           wrAddrReg <= addrReg;
                           wrDataReg <= shiftNext[7:0];
                        end
                     end
                  end
                  else if (sclkFall && isRead)
                  begin
                     sdioOut <= rdShift[7];
                     sdioOe  <= 1'b1;
                     rdShift <= {rdShift[6:0], 1'b0};
                  end
               end
               default: spiState <= SPI_IDLE;
            endcase
         end
      end
   end

   // Register file; soft reset returns every register to default
   logic softRstReg;
   logic ctrlWrite;
   logic restartNow;
   logic [3:0] restartMode;
   assign ctrlWrite = wrEnReg && (wrAddrReg == `ADDR_LTCTRL);
   // Restart on a changed mode or point
   assign restartNow = softRstReg ||
                       (ctrlWrite && (wrDataReg[`POINT_MSB:`MODE_LSB] != ctrlReg));
   assign restartMode = softRstReg ? `MODE_OFF : wrDataReg[`MODE_MSB:`MODE_LSB];

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         softRstReg <= 1'b0;
         ifCfgReg   <= '0;
         ctrlReg    <= `LTCTRL_RESET;
         lltReg     <= '0;
         for (int k = 0; k < 8; k++)
            userPat[k] <= '0;
      end
      else if (softRstReg)
      begin
         // Reset performed, request bits never stored
         softRstReg <= 1'b0;
         ifCfgReg   <= '0;
         ctrlReg    <= `LTCTRL_RESET;
         lltReg     <= '0;
         for (int k = 0; k < 8; k++)
            userPat[k] <= '0;
      end
      else if (wrEnReg)
      begin
         if (wrAddrReg == `ADDR_IFCFG)
         begin
            softRstReg <= |(wrDataReg & `IFCFG_SRST_MASK);
            ifCfgReg   <= wrDataReg & `IFCFG_KEEP_MASK;
         end
         if (ctrlWrite)
            ctrlReg <= wrDataReg[`POINT_MSB:`MODE_LSB];
         // Stored for the link layer; no effect here
         if (wrAddrReg == `ADDR_LLTCTRL)
            lltReg <= wrDataReg;
         if (wrAddrReg >= `ADDR_UPAT_FIRST && wrAddrReg <= `ADDR_UPAT_LAST)
            userPat[3'(wrAddrReg - `ADDR_UPAT_FIRST)] <= wrDataReg;
      end
   end

   // Generator state
   logic        phase;
   logic [15:0] ramp;
   logic [1:0]  userIdx;
   logic        userDone;
   logic [30:0] lfsr;
   logic [1:0]  slotCnt;
   logic        patActive;
   logic        pushFire;
   logic        advance;
   logic [4:0]  wordW;
   logic [15:0] widthMask;
   logic [15:0] userWord;
   logic [15:0] patWord;
   prbs_s       prbsNow;
   link_word_s  pushWord;

   assign wordW     = widthOf(ctrlReg.point);
   assign widthMask = 16'(16'hFFFF >> (5'd16 - wordW));
   assign prbsNow   = prbsNext(lfsr, ctrlReg.mode, wordW);
   // Byte pairs form words, low byte first
   assign userWord  = {userPat[{userIdx, 1'b1}], userPat[{userIdx, 1'b0}]};
   assign patActive = (ctrlReg.mode != `MODE_OFF) &&
                      ((ctrlReg.mode <= `MODE_RAMP) || (ctrlReg.mode >= `MODE_UREP));
   assign pushFire  = srcValid && srcReady;
   // Advance per frame, symbol or octet
   assign advance   = pushFire && patActive &&
                      ((ctrlReg.point != `PT_SAMPLE) || (slotCnt == `FRAME_SLOT_LAST));

   // Pattern word for the current step
   always_comb
   begin
      case (ctrlReg.mode)
         `MODE_ALT:    patWord = (phase ? ~`ALT_WORD : `ALT_WORD) & widthMask;
         `MODE_TOGGLE: patWord = phase ? widthMask : 16'h0000;
         `MODE_RAMP:   patWord = ramp & widthMask;
         `MODE_UREP:   patWord = 16'(userWord >> (5'd16 - wordW));
         `MODE_USGL:   patWord = userDone ? 16'h0000 : 16'(userWord >> (5'd16 - wordW));
         default:      patWord = prbsNow.word;
      endcase
   end

   // Sequence state steps only when a word is taken
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase    <= 1'b0;
         ramp     <= '0;
         userIdx  <= '0;
         userDone <= 1'b0;
         lfsr     <= `SEED_PN7;
         slotCnt  <= '0;
      end
      else if (restartNow)
      begin
         phase    <= 1'b0;
         ramp     <= '0;
         userIdx  <= '0;
         userDone <= 1'b0;
         lfsr     <= seedFor(restartMode);
         slotCnt  <= '0;
      end
      else
      begin
         if (pushFire && patActive && ctrlReg.point == `PT_SAMPLE)
            slotCnt <= 2'(slotCnt + 1'b1);
         if (advance)
         begin
            phase   <= !phase;
            ramp    <= 16'(ramp + 1'b1);
            userIdx <= 2'(userIdx + 1'b1);
            lfsr    <= prbsNow.state;
            if (userIdx == `USER_IDX_LAST)
               userDone <= 1'b1;
         end
      end
   end

   // Substitute the pattern while a mode is active
   assign pushWord.point = ctrlReg.point;
   assign pushWord.data  = patActive ? patWord : srcWord;

   link_word_fifo #(.WIDTH($bits(link_word_s)), .DEPTH(`FIFO_DEPTH)) uFifo
   (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (srcValid),
      .inData   (pushWord),
      .inReady  (srcReady),
      .outValid (linkValid),
      .outData  (linkWord),
      .outReady (linkReady)
   );

   a_pass_through: assert property (@(posedge clk) disable iff (!rst_b)
      pushFire && !patActive |-> pushWord.data == srcWord)
      else $error("normal word altered while off");
   a_soft_clear: assert property (@(posedge clk) disable iff (!rst_b)
      wrEnReg && wrAddrReg == `ADDR_IFCFG && wrDataReg == `IFCFG_SRST_MASK
      |=> softRstReg ##1 (ctrlReg == `LTCTRL_RESET && ifCfgReg == 8'h00))
      else $error("soft reset did not clear");
   a_alt_flip: assert property (@(posedge clk) disable iff (!rst_b)
      advance && ctrlReg.mode == `MODE_ALT && !restartNow && !ctrlWrite
      |=> patWord == ($past(patWord) ^ widthMask))
      else $error("checkerboard did not alternate");
   a_ramp_step: assert property (@(posedge clk) disable iff (!rst_b)
      advance && ctrlReg.mode == `MODE_RAMP && !restartNow && !ctrlWrite
      |=> patWord == (16'($past(patWord) + 1'b1) & widthMask))
      else $error("ramp step wrong");
   a_user_wrap: assert property (@(posedge clk) disable iff (!rst_b)
      advance && ctrlReg.mode == `MODE_UREP && userIdx == 2'h3 && !restartNow
      |=> userIdx == 2'h0 && !restartNow |-> patWord ==
      16'({userPat[1], userPat[0]} >> (5'd16 - wordW)))
      else $error("user repeat did not wrap");
   a_single_zero: assert property (@(posedge clk) disable iff (!rst_b)
      ctrlReg.mode == `MODE_USGL && userDone |-> patWord == 16'h0000)
      else $error("single user pattern not zero");
   a_frame_hold: assert property (@(posedge clk) disable iff (!rst_b)
      pushFire && patActive && ctrlReg.point == `PT_SAMPLE && slotCnt != 2'h3 &&
      !restartNow && !wrEnReg |=> patWord == $past(patWord))
      else $error("pattern moved inside a frame");
   a_restart_seed: assert property (@(posedge clk) disable iff (!rst_b)
      restartNow |=> lfsr == seedFor(ctrlReg.mode) && ramp == 16'h0000 && userIdx == 2'h0)
      else $error("sequence not restarted");
   a_sdio_drive: assert property (@(posedge clk) disable iff (!rst_b)
      sdioOe |-> isRead && !$past(csIdle))
      else $error("data pin driven outside a read");
endmodule : link_tpg

// ### verif/link_rx_model.sv
// Purpose: Receiver model that takes words from the pattern generator
// Assumes: The bench paces it through stall and slow
// Notes: Received words wait in rxq until the bench reads them
`timescale 1ns/100ps
module link_rx_model
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // Words from the generator
   input  wire logic                     linkValid,
   input  wire link_tpg_pkg::link_word_s linkWord,
   output logic                          linkReady,
   // Pacing from the bench
   input  wire logic                     stall,
   input  wire logic                     slow
);
   import link_tpg_pkg::*;
   link_word_s rxq [$];
   logic       phaseReg;
   // Take on the agreed edge; slow pacing halves the rate so the FIFO backs up
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         linkReady <= 1'b0;
         phaseReg  <= 1'b0;
      end
      else
      begin
         if (linkValid === 1'b1 && linkReady === 1'b1)
            rxq.push_back(linkWord);
         phaseReg  <= ~phaseReg;
         linkReady <= !stall && (!slow || phaseReg);
      end
   end
endmodule : link_rx_model

// ### verif/test_link_tpg.sv
// Purpose: Self-checking bench for the link test pattern generator
// Assumes: Serial port half periods of six clk cycles
// Notes: Normal datapath word is 16'h1234 so pass-through is easy to spot
`timescale 1ns/100ps
`include "link_tpg_defines.svh"
`define CHK(a, e) \
   begin \
      cmpCount++; \
      if ((a) !== (e)) \
      begin \
         errCount++; \
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); \
      end \
   end
module test_link_tpg;
   import link_tpg_pkg::*;
   logic        clk;
   logic        rst_b;
   logic        spiClk;
   logic        spiCs_b;
   logic        hostBit;
   logic        sdioIn;
   logic        sdioOut;
   logic        sdioOe;
   logic        srcValid;
   logic [15:0] srcWord;
   logic        srcReady;
   logic        linkValid;
   link_word_s  linkWord;
   logic        linkReady;
   logic        stall;
   logic        slow;
   int          errCount;
   int          cmpCount;
   int          cycles;
   // Shared data pin: the device wins while it drives
   assign sdioIn = sdioOe ? sdioOut : hostBit;
   link_tpg link_tpg_inst
   (
      .clk(clk), .rst_b(rst_b), .spiClk(spiClk), .spiCs_b(spiCs_b), .sdioIn(sdioIn),
      .sdioOut(sdioOut), .sdioOe(sdioOe), .srcValid(srcValid), .srcWord(srcWord),
      .srcReady(srcReady), .linkValid(linkValid), .linkWord(linkWord), .linkReady(linkReady)
   );
   link_rx_model link_rx_model_inst
   (
      .clk(clk), .rst_b(rst_b), .linkValid(linkValid), .linkWord(linkWord),
      .linkReady(linkReady), .stall(stall), .slow(slow)
   );
   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Hang guard, far above the roughly 11000 cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         errCount++;
         testDone();
      end
   end
   task automatic testDone;
      if (errCount == 0 && cmpCount > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : testDone
   // Inputs always move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // One serial frame: 16-bit instruction then one data byte, MSB first
   task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat);
      logic [23:0] sh;
      sh = {rd, a, wd};
      rdat = 8'h00;
      spiCs_b = 1'b0;
      tick(3);
      for (int i = 23; i >= 0; i--)
      begin
         hostBit = sh[i];
         tick(6);
         if (i < 8)
            rdat[i] = sdioOut;
         spiClk = 1'b1;
         tick(6);
         spiClk = 1'b0;
      end
      tick(6);
      spiCs_b = 1'b1;
      hostBit = ~hostBit;
      tick(6);
   endtask : spi
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] unused;
      spi(1'b0, a, d, unused);
   endtask : wr
   task automatic rd(input logic [14:0] a, output logic [7:0] d);
      spi(1'b1, a, 8'h00, d);
   endtask : rd
   // Mode in the low nibble, point in bits five to four
   task automatic setMode(input logic [3:0] m, input logic [1:0] p);
      wr(`ADDR_LTCTRL, {2'b00, p, m});
   endtask : setMode
   // Offer n words, counting only those the block accepts
   task automatic push(input int n);
      int k;
      k = 0;
      srcValid = 1'b1;
      while (k < n)
      begin
         if (srcReady === 1'b1)
            k++;
         tick(1);
      end
      srcValid = 1'b0;
   endtask : push
   task automatic take(output link_word_s w);
      while (link_rx_model_inst.rxq.size() == 0)
         tick(1);
      w = link_rx_model_inst.rxq.pop_front();
   endtask : take
   // Each expected word is seen rep times in a row
   task automatic expectWords(input logic [1:0] pt, input int rep, input logic [15:0] e [$]);
      link_word_s w;
      foreach (e[i])
      begin
         repeat (rep)
         begin
            take(w);
            `CHK(w.point, pt)
            `CHK(w.data, e[i])
         end
      end
   endtask : expectWords
   task automatic resetScen;
      logic [7:0] r;
      rd(`ADDR_LTCTRL, r);
      `CHK(r, 8'h00)
      rd(15'h0100, r);
      `CHK(r, 8'h00)
      push(2);
      expectWords(`PT_SAMPLE, 1, '{16'h1234, 16'h1234});
      wr(`ADDR_LLTCTRL, 8'h01);
      // Sync input off while link layer tests run
      wr(15'h0572, 8'hC0);
      rd(`ADDR_LLTCTRL, r);
      `CHK(r, 8'h01)
   endtask : resetScen
   task automatic pointScen;
      setMode(`MODE_ALT, `PT_SAMPLE);
      push(8);
      expectWords(`PT_SAMPLE, 4, '{16'h5555, 16'hAAAA});
      setMode(`MODE_PN9, `PT_SAMPLE);
      push(8);
      expectWords(`PT_SAMPLE, 4, '{16'h496F, 16'hC9A9});
      setMode(`MODE_TOGGLE, `PT_SYMBOL);
      push(2);
      expectWords(`PT_SYMBOL, 1, '{16'h0000, 16'h03FF});
      setMode(`MODE_PN9, `PT_SYMBOL);
      push(4);
      expectWords(`PT_SYMBOL, 1, '{16'h0125, 16'h02FC, 16'h026A, 16'h0198});
      setMode(`MODE_PRBS_TWENTYTHREE_STAGE, `PT_OCTET);
      push(4);
      expectWords(`PT_OCTET, 1, '{16'h00FF, 16'h005C, 16'h0000, 16'h0029});
      setMode(`MODE_PN9, `PT_OCTET);
      push(1);
      expectWords(`PT_OCTET, 1, '{16'h0049});
      setMode(`MODE_PN7, `PT_OCTET);
      setMode(`MODE_PN9, `PT_OCTET);
      push(2);
      expectWords(`PT_OCTET, 1, '{16'h0049, 16'h006F});
   endtask : pointScen
   task automatic userScen;
      logic [7:0] ub [8];
      logic [7:0] r;
      ub = '{8'hC4, 8'hA2, 8'h5B, 8'h3E, 8'h80, 8'hF7, 8'h2D, 8'h69};
      for (int i = 0; i < 8; i++)
         wr(`ADDR_UPAT_FIRST + 15'(i), ub[i]);
      rd(`ADDR_UPAT_LAST, r);
      `CHK(r, 8'h69)
      setMode(`MODE_UREP, `PT_SYMBOL);
      push(5);
      expectWords(`PT_SYMBOL, 1, '{16'h028B, 16'h00F9, 16'h03DE, 16'h01A4, 16'h028B});
      setMode(`MODE_USGL, `PT_SAMPLE);
      push(20);
      expectWords(`PT_SAMPLE, 4, '{16'hA2C4, 16'h3E5B, 16'hF780, 16'h692D, 16'h0000});
   endtask : userScen
   // Any pass-through at the octet point would show 8'h12 in the high byte
   task automatic modeScen;
      link_word_s w;
      logic [3:0] modes [$];
      modes = '{`MODE_TOGGLE, `MODE_PN31, `MODE_PN15, `MODE_PN7, `MODE_USGL};
      foreach (modes[i])
      begin
         setMode(modes[i], `PT_OCTET);
         push(1);
         take(w);
         `CHK(w.data[15:8], 8'h00)
      end
      // Undefined modes leave the normal word untouched
      setMode(4'h9, `PT_OCTET);
      push(1);
      take(w);
      `CHK(w.data, 16'h1234)
   endtask : modeScen
   // Ramp runs past the 8-bit wrap while the receiver is slow
   task automatic rampScen;
      link_word_s w;
      logic [7:0] prev;
      setMode(`MODE_RAMP, `PT_OCTET);
      slow = 1'b1;
      push(260);
      take(w);
      `CHK(w.data, 16'h0000)
      prev = w.data[7:0];
      for (int i = 1; i < 260; i++)
      begin
         take(w);
         `CHK(w.data, {8'h00, prev + 8'h01})
         prev = w.data[7:0];
      end
      slow = 1'b0;
   endtask : rampScen
   task automatic resetFifoScen;
      logic [7:0] r;
      int k;
      setMode(`MODE_OFF, `PT_SAMPLE);
      wr(`ADDR_IFCFG, `IFCFG_SRST_MASK);
      rd(`ADDR_IFCFG, r);
      `CHK(r, 8'h00)
      rd(`ADDR_UPAT_FIRST, r);
      `CHK(r, 8'h00)
      stall = 1'b1;
      srcValid = 1'b1;
      k = 0;
      repeat (30)
      begin
         if (srcReady === 1'b1)
            k++;
         tick(1);
      end
      srcValid = 1'b0;
      `CHK(k, `FIFO_DEPTH + 1)
      stall = 1'b0;
      expectWords(`PT_SAMPLE, 9, '{16'h1234});
   endtask : resetFifoScen
   // Main sequence
   initial
   begin
      rst_b = 1'b0;
      spiClk = 1'b0;
      spiCs_b = 1'b1;
      hostBit = 1'b0;
      srcValid = 1'b0;
      srcWord = 16'h1234;
      stall = 1'b0;
      slow = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      rst_b = 1'b1;
      tick(2);
      resetScen();
      pointScen();
      userScen();
      modeScen();
      rampScen();
      resetFifoScen();
      testDone();
   end
endmodule : test_link_tpg
